// [common/ohb_pkg.sv]
// Shared constants, types and helpers of the display host port.
`default_nettype none
package ohb_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int RES_LOW_MIN_NS = 3000;
	localparam int RES_LOW_MIN_CYC = (RES_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// Widths and pin positions
	// ****************************************
	localparam int DATA_W = 8;
	localparam int WORD_W = 9;
	localparam int SYNC_W = 15;
	localparam int SY_DATA_LO = 0;
	localparam int SY_EN_RD = 8;
	localparam int SY_RW_WR = 9;
	localparam int SY_DC = 10;
	localparam int SY_CS_N = 11;
	localparam int SY_BS_LO = 12;
	localparam int SY_BS_HI = 13;
	localparam int SY_RES_N = 14;
	// Pins idle high, but the reset pin reads low so init holds until its real level arrives
	localparam logic [SYNC_W-1:0] SYNC_RESET = 15'h3fff;
	localparam int SPI_CLK_BIT = 0;
	localparam int SPI_DAT_BIT = 1;
	localparam int I2C_SCL_BIT = 0;
	localparam int I2C_SDA_IN_BIT = 1;
	localparam logic [7:0] I2C_SDA_OUT_MASK = 8'h04;
	localparam logic [7:0] BUS_ALL = 8'hff;
	localparam logic [7:0] BUS_NONE = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [2:0] SPI_LAST_BIT = 3'h7;
	localparam int I2C_CO_BIT = 7;
	localparam int I2C_DC_BIT = 6;
	localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h2a;

	// ****************************************
	// Modes and states
	// ****************************************
	// Straps as {bus_select_hi, bus_select_lo}
	localparam logic [1:0] STRAP_EPAR = 2'h2;
	localparam logic [1:0] STRAP_SPAR = 2'h3;
	localparam logic [1:0] STRAP_SPI = 2'h0;
	localparam logic [1:0] STRAP_I2C = 2'h1;

	typedef enum logic [3:0] {
		OHB_MODE_EPAR = 4'h1,
		OHB_MODE_SPAR = 4'h2,
		OHB_MODE_SPI = 4'h4,
		OHB_MODE_I2C = 4'h8
	} ohb_mode_e;

	typedef enum logic [3:0] {
		OHB_I2C_IDLE = 4'h1,
		OHB_I2C_ADDR = 4'h2,
		OHB_I2C_CTRL = 4'h4,
		OHB_I2C_DATA = 4'h8
	} ohb_i2c_e;

	function automatic ohb_mode_e ohb_strap_decode(input logic [1:0] straps);
		case (straps)
			STRAP_EPAR: ohb_strap_decode = OHB_MODE_EPAR;
			STRAP_SPAR: ohb_strap_decode = OHB_MODE_SPAR;
			STRAP_I2C: ohb_strap_decode = OHB_MODE_I2C;
			default: ohb_strap_decode = OHB_MODE_SPI;
		endcase
	endfunction : ohb_strap_decode
endpackage : ohb_pkg
`default_nettype wire

// [hw/ohb_skid_buf.sv]
// Two-entry buffer with valid and ready on both sides, registered outputs.
`default_nettype none
module ohb_skid_buf #(
	parameter int W = ohb_pkg::WORD_W
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_word,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_word
);
	import ohb_pkg::*;

	logic [W-1:0] main_q;
	logic [W-1:0] spare_q;
	logic main_v_q;
	logic spare_v_q;
	logic pop;
	logic push;

	assign pop = main_v_q & out_ready;
	assign push = in_valid & ~spare_v_q;
	assign in_ready = ~spare_v_q;
	assign out_valid = main_v_q;
	assign out_word = main_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			main_q <= '0;
			spare_q <= '0;
			main_v_q <= 1'b0;
			spare_v_q <= 1'b0;
		end else if (spare_v_q) begin
			if (pop) begin
				main_q <= spare_q;
				spare_v_q <= 1'b0;
			end
		end else if (push && (!main_v_q || pop)) begin
			main_q <= in_word;
			main_v_q <= 1'b1;
		end else if (push) begin
			spare_q <= in_word;
			spare_v_q <= 1'b1;
		end else if (pop) begin
			main_v_q <= 1'b0;
		end
	end
endmodule : ohb_skid_buf
`default_nettype wire

// [hw/ohb_host_if.sv]
// Host bus port of the display driver: parallel, serial and I2C byte intake.
// Operation
// - Transfers are honoured only while chip-select is low.
// - Reset pin low holds the whole port in initialisation.
// - Qualifier low marks a command byte, high marks display data.
// - Enable-strobe mode: direction high means read, low means write.
// - Enable-strobe mode: transfer starts on enable rising while selected.
// - Separate-strobe mode: write starts when write strobe falls while selected.
// - Separate-strobe mode: read starts when read strobe falls while selected.
// - Parallel modes use an 8-bit bus, device drives only in reads.
// - 4-wire serial: bit 0 is clock, bit 1 data, bit 2 unused.
// - I2C: bits 2 and 1 joined as data out/in, bit 0 clock.
// - Straps select enable, separate, serial or I2C mode.
`default_nettype none
module ohb_host_if #(
	parameter logic [6:0] I2C_ADDR = ohb_pkg::I2C_ADDR_DEFAULT
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Straps and control pins
	input wire logic reset_in_n,
	input wire logic bus_select_lo,
	input wire logic bus_select_hi,
	input wire logic chip_sel_n,
	input wire logic cmd_data_sel,
	input wire logic rw_wr_n,
	input wire logic en_rd_n,
	// Data pins
	input wire logic [7:0] host_data_bus_i,
	output logic [7:0] host_data_bus_o,
	output logic [7:0] host_data_bus_oe,
	// Received bytes
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_byte,
	output logic rx_is_data,
	// Read return
	input wire logic [7:0] rd_data,
	output logic rd_strobe,
	// Status
	output logic init_active,
	output ohb_pkg::ohb_mode_e host_mode,
	output logic rx_overrun
);
	import ohb_pkg::*;

	// ****************************************
	// Pin synchronisers and edges
	// ****************************************
	logic [SYNC_W-1:0] s1_q;
	logic [SYNC_W-1:0] s2_q;
	logic [SYNC_W-1:0] s3_q;
	logic init;
	logic sel;
	logic [7:0] dat_s;
	logic en_rise, en_fall, wr_fall, wr_rise, rd_fall, rd_rise;
	logic sclk_rise, scl_rise, scl_fall, scl_s, sda_s, sda_rise, sda_fall;

	always_ff @(posedge clock) begin
		if (rst) begin
			s1_q <= SYNC_RESET;
			s2_q <= SYNC_RESET;
			s3_q <= SYNC_RESET;
		end else begin
			s1_q <= {reset_in_n, bus_select_hi, bus_select_lo, chip_sel_n, cmd_data_sel,
				rw_wr_n, en_rd_n, host_data_bus_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign init = rst | ~s2_q[SY_RES_N];
	assign sel = ~s2_q[SY_CS_N];
	assign dat_s = s2_q[SY_DATA_LO +: DATA_W];
	assign en_rise = s2_q[SY_EN_RD] & ~s3_q[SY_EN_RD];
	assign en_fall = ~s2_q[SY_EN_RD] & s3_q[SY_EN_RD];
	assign rd_fall = en_fall;
	assign rd_rise = en_rise;
	assign wr_fall = ~s2_q[SY_RW_WR] & s3_q[SY_RW_WR];
	assign wr_rise = s2_q[SY_RW_WR] & ~s3_q[SY_RW_WR];
	assign sclk_rise = s2_q[SPI_CLK_BIT] & ~s3_q[SPI_CLK_BIT];
	assign scl_s = s2_q[I2C_SCL_BIT];
	assign scl_rise = scl_s & ~s3_q[I2C_SCL_BIT];
	assign scl_fall = ~scl_s & s3_q[I2C_SCL_BIT];
	assign sda_s = s2_q[I2C_SDA_IN_BIT];
	assign sda_rise = sda_s & ~s3_q[I2C_SDA_IN_BIT];
	assign sda_fall = ~sda_s & s3_q[I2C_SDA_IN_BIT];

	// ****************************************
	// Initialisation and mode
	// ****************************************
	ohb_mode_e mode_q;

	always_ff @(posedge clock) begin
		init_active <= init;
		if (init) begin
			mode_q <= ohb_strap_decode({s2_q[SY_BS_HI], s2_q[SY_BS_LO]});
		end
	end
	assign host_mode = mode_q;

	// ****************************************
	// Parallel modes
	// ****************************************
	logic wr_pend_q;
	logic rd_drive_q;
	logic par_push_q;
	logic [WORD_W-1:0] par_word_q;
	logic [7:0] rd_hold_q;

	always_ff @(posedge clock) begin
		par_push_q <= 1'b0;
		rd_strobe <= 1'b0;
		if (init || !sel) begin
			wr_pend_q <= 1'b0;
			rd_drive_q <= 1'b0;
			if (init) begin
				par_word_q <= '0;
				rd_hold_q <= '0;
			end
		end else if (mode_q == OHB_MODE_EPAR) begin
			if (en_rise) begin
				if (s2_q[SY_RW_WR]) begin
					rd_drive_q <= 1'b1;
					rd_hold_q <= rd_data;
					rd_strobe <= 1'b1;
				end else begin
					wr_pend_q <= 1'b1;
				end
			end else if (en_fall) begin
				rd_drive_q <= 1'b0;
				if (wr_pend_q) begin
					wr_pend_q <= 1'b0;
					par_push_q <= 1'b1;
					par_word_q <= {s2_q[SY_DC], dat_s};
				end
			end
		end else if (mode_q == OHB_MODE_SPAR) begin
			if (wr_fall) begin
				wr_pend_q <= 1'b1;
			end else if (wr_rise && wr_pend_q) begin
				wr_pend_q <= 1'b0;
				par_push_q <= 1'b1;
				par_word_q <= {s2_q[SY_DC], dat_s};
			end
			if (rd_fall) begin
				rd_drive_q <= 1'b1;
				rd_hold_q <= rd_data;
				rd_strobe <= 1'b1;
			end else if (rd_rise) begin
				rd_drive_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// 4-wire serial mode
	// ****************************************
	logic [2:0] spi_cnt_q;
	logic [6:0] spi_sh_q;
	logic spi_push_q;
	logic [WORD_W-1:0] spi_word_q;

	always_ff @(posedge clock) begin
		spi_push_q <= 1'b0;
		if (init) begin
			spi_cnt_q <= '0;
			spi_sh_q <= '0;
			spi_word_q <= '0;
		end else if (!sel || mode_q != OHB_MODE_SPI) begin
			spi_cnt_q <= '0;
		end else if (sclk_rise) begin
			spi_sh_q <= {spi_sh_q[5:0], s2_q[SPI_DAT_BIT]};
			spi_cnt_q <= spi_cnt_q + 3'h1;
			if (spi_cnt_q == SPI_LAST_BIT) begin
				spi_push_q <= 1'b1;
				spi_word_q <= {s2_q[SY_DC], spi_sh_q, s2_q[SPI_DAT_BIT]};
			end
		end
	end

	// ****************************************
	// I2C mode
	// ****************************************
	ohb_i2c_e i2c_st_q;
	logic [3:0] i2c_cnt_q;
	logic [7:0] i2c_sh_q;
	logic i2c_ack_q;
	logic i2c_co_q;
	logic i2c_dc_q;
	logic i2c_push_q;
	logic [WORD_W-1:0] i2c_word_q;
	logic buf_ready;

	always_ff @(posedge clock) begin
		i2c_push_q <= 1'b0;
		if (init || mode_q != OHB_MODE_I2C || !sel) begin
			i2c_st_q <= OHB_I2C_IDLE;
			i2c_cnt_q <= '0;
			i2c_ack_q <= 1'b0;
			if (init) begin
				i2c_sh_q <= '0;
				i2c_co_q <= 1'b0;
				i2c_dc_q <= 1'b0;
				i2c_word_q <= '0;
			end
		end else if (scl_s && sda_fall) begin
			i2c_st_q <= OHB_I2C_ADDR;
			i2c_cnt_q <= '0;
			i2c_ack_q <= 1'b0;
		end else if (scl_s && sda_rise) begin
			i2c_st_q <= OHB_I2C_IDLE;
			i2c_ack_q <= 1'b0;
		end else if (i2c_st_q != OHB_I2C_IDLE) begin
			if (scl_rise && !i2c_ack_q) begin
				i2c_sh_q <= {i2c_sh_q[6:0], sda_s};
				i2c_cnt_q <= i2c_cnt_q + 4'h1;
			end else if (scl_fall && i2c_ack_q) begin
				i2c_ack_q <= 1'b0;
			end else if (scl_fall && i2c_cnt_q == BITS_PER_BYTE) begin
				i2c_cnt_q <= '0;
				case (i2c_st_q)
					OHB_I2C_ADDR: begin
						if (i2c_sh_q[7:1] == I2C_ADDR && !i2c_sh_q[0]) begin
							i2c_ack_q <= 1'b1;
							i2c_st_q <= OHB_I2C_CTRL;
						end else begin
							i2c_st_q <= OHB_I2C_IDLE;
						end
					end
					OHB_I2C_CTRL: begin
						i2c_co_q <= i2c_sh_q[I2C_CO_BIT];
						i2c_dc_q <= i2c_sh_q[I2C_DC_BIT];
						i2c_ack_q <= 1'b1;
						i2c_st_q <= OHB_I2C_DATA;
					end
					OHB_I2C_DATA: begin
						i2c_push_q <= buf_ready;
						i2c_word_q <= {i2c_dc_q, i2c_sh_q};
						i2c_ack_q <= buf_ready;
						i2c_st_q <= !buf_ready ? OHB_I2C_IDLE :
							(i2c_co_q ? OHB_I2C_CTRL : OHB_I2C_DATA);
					end
					default: i2c_st_q <= OHB_I2C_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// Pad drive
	// ****************************************
	always_ff @(posedge clock) begin
		if (init) begin
			host_data_bus_o <= BUS_NONE;
			host_data_bus_oe <= BUS_NONE;
		end else if (rd_drive_q) begin
			host_data_bus_o <= rd_hold_q;
			host_data_bus_oe <= BUS_ALL;
		end else if (i2c_ack_q) begin
			host_data_bus_o <= BUS_NONE;
			host_data_bus_oe <= I2C_SDA_OUT_MASK;
		end else begin
			host_data_bus_o <= BUS_NONE;
			host_data_bus_oe <= BUS_NONE;
		end
	end

	// ****************************************
	// Byte buffer
	// ****************************************
	logic buf_in_valid;
	logic [WORD_W-1:0] buf_in_word;
	logic [WORD_W-1:0] buf_out_word;

	assign buf_in_valid = par_push_q | spi_push_q | i2c_push_q;
	assign buf_in_word = par_push_q ? par_word_q : (spi_push_q ? spi_word_q : i2c_word_q);

	always_ff @(posedge clock) begin
		if (init) begin
			rx_overrun <= 1'b0;
		end else if (buf_in_valid && !buf_ready) begin
			rx_overrun <= 1'b1;
		end
	end

	ohb_skid_buf #(.W(WORD_W)) u_buf (
		.clock(clock),
		.rst(init),
		.in_valid(buf_in_valid),
		.in_ready(buf_ready),
		.in_word(buf_in_word),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_word(buf_out_word)
	);
	assign rx_byte = buf_out_word[DATA_W-1:0];
	assign rx_is_data = buf_out_word[DATA_W];
endmodule : ohb_host_if
`default_nettype wire

// [test/ohb_host_if_props.sv]
// Concurrent checks on the display host port outputs.
`default_nettype none
module ohb_host_if_props (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Pins
	input wire logic chip_sel_n,
	input wire logic [7:0] rd_data,
	input wire logic [7:0] host_data_bus_o,
	input wire logic [7:0] host_data_bus_oe,
	// Outputs
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic [7:0] rx_byte,
	input wire logic rx_is_data,
	input wire logic rd_strobe,
	input wire logic init_active,
	input wire ohb_pkg::ohb_mode_e host_mode
);
	import ohb_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	init_quiet_a: assert property (init_active |-> !host_data_bus_oe && !rx_valid && !rd_strobe)
		else $error("port active during init");
	rd_pulse_a: assert property (rd_strobe |=> !rd_strobe)
		else $error("read start longer than one cycle");
	rd_drive_a: assert property (rd_strobe && host_mode inside {OHB_MODE_EPAR, OHB_MODE_SPAR}
		|=> host_data_bus_oe == 8'hff && host_data_bus_o == $past(rd_data, 2))
		else $error("read data not driven");
	spi_quiet_a: assert property (host_mode == OHB_MODE_SPI |-> host_data_bus_oe == 8'h00)
		else $error("bus driven in serial mode");
	i2c_pins_a: assert property (host_mode == OHB_MODE_I2C |-> host_data_bus_oe inside {8'h00, 8'h04})
		else $error("wrong pin driven in i2c mode");
	rd_mode_a: assert property (rd_strobe |-> host_mode inside {OHB_MODE_EPAR, OHB_MODE_SPAR})
		else $error("read start outside parallel mode");
	desel_idle_a: assert property (chip_sel_n [*6] |-> !rd_strobe)
		else $error("read while deselected");
	head_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_byte)
		&& $stable(rx_is_data))
		else $error("stalled byte changed");
	cover property (rx_valid && rx_ready);
	cover property (rd_strobe);
	cover property ($rose(rx_valid) && rx_is_data);
	cover property (host_data_bus_oe == 8'h04);
endmodule : ohb_host_if_props
bind ohb_host_if ohb_host_if_props chk (.clock, .rst, .chip_sel_n, .rd_data, .host_data_bus_o,
	.host_data_bus_oe, .rx_valid, .rx_ready, .rx_byte, .rx_is_data, .rd_strobe, .init_active,
	.host_mode);
`default_nettype wire

// [test/ohb_host_model.sv]
// Host microcontroller model driving the port pins.
`default_nettype none
module ohb_host_model (
	// Clock
	input wire logic clock,
	// Control pins
	output logic reset_in_n,
	output logic bus_select_lo,
	output logic bus_select_hi,
	output logic chip_sel_n,
	output logic cmd_data_sel,
	output logic rw_wr_n,
	output logic en_rd_n,
	// Data pins
	output logic [7:0] host_data_bus_i,
	input wire logic [7:0] host_data_bus_o,
	input wire logic [7:0] host_data_bus_oe
);
	logic [7:0] drv_q;
	assign host_data_bus_i = (host_data_bus_oe & host_data_bus_o) | (~host_data_bus_oe & drv_q);
	initial begin
		{reset_in_n, bus_select_lo, bus_select_hi, cmd_data_sel, rw_wr_n, en_rd_n} = 6'h00;
		chip_sel_n = 1'b1;
		drv_q = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic set_mode(input logic [1:0] hl);
		@(posedge clock);
		reset_in_n <= 1'b0;
		{bus_select_hi, bus_select_lo} <= hl;
		{rw_wr_n, en_rd_n} <= (hl == 2'h3) ? 2'h3 : 2'h0;
		drv_q <= 8'h00;
		tick(ohb_pkg::RES_LOW_MIN_CYC);
		reset_in_n <= 1'b1;
		tick(6);
	endtask : set_mode
	task automatic par(input logic sel_n, rd, dc, input logic [7:0] b, output logic [7:0] got);
		@(posedge clock);
		chip_sel_n <= sel_n;
		cmd_data_sel <= dc;
		drv_q <= rd ? ~drv_q : b;
		if (!bus_select_lo) rw_wr_n <= rd;
		tick(2);
		if (bus_select_lo) {rw_wr_n, en_rd_n} <= {rd, !rd};
		else en_rd_n <= 1'b1;
		tick(8);
		got = host_data_bus_i;
		{rw_wr_n, en_rd_n} <= bus_select_lo ? 2'h3 : {rw_wr_n, 1'b0};
		tick(4);
		chip_sel_n <= 1'b1;
		drv_q <= ~drv_q;
	endtask : par
	task automatic spi(input logic dc, input logic [7:0] b);
		@(posedge clock);
		chip_sel_n <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			drv_q <= {drv_q[7:2], b[i], 1'b0};
			if (i == 0) cmd_data_sel <= dc;
			tick(4);
			drv_q[0] <= 1'b1;
			tick(4);
		end
		drv_q <= {drv_q[7:2], ~b[0], 1'b0};
		tick(4);
		chip_sel_n <= 1'b1;
	endtask : spi
	// Start, three bytes each followed by an acknowledge slot, stop
	task automatic i2c(input logic [23:0] bytes, output logic [2:0] acks);
		@(posedge clock);
		chip_sel_n <= 1'b0;
		drv_q <= 8'h03;
		tick(4);
		drv_q[1] <= 1'b0;
		tick(4);
		for (int k = 2; k >= 0; k--) begin
			for (int i = 7; i >= 0; i--) begin
				drv_q <= {drv_q[7:2], bytes[8 * k + i], 1'b0};
				tick(4);
				drv_q[0] <= 1'b1;
				tick(4);
			end
			drv_q <= {drv_q[7:2], 2'h2};
			tick(4);
			drv_q[0] <= 1'b1;
			tick(4);
			acks[k] = host_data_bus_oe[2] & ~host_data_bus_o[2];
		end
		drv_q <= {drv_q[7:2], 2'h0};
		tick(4);
		drv_q[0] <= 1'b1;
		tick(4);
		drv_q[1] <= 1'b1;
		tick(4);
		chip_sel_n <= 1'b1;
	endtask : i2c
endmodule : ohb_host_model
`default_nettype wire

// [test/test_oled_host_bus_interface.sv]
// Self-checking bench of the display host port.
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin mismatches++; \
	$display("Error %s expected %h seen %h", n, e, s); end end
module test_oled_host_bus_interface;
	timeunit 1ns;
	timeprecision 1ns;
	import ohb_pkg::*;
	logic clock, rst, rx_ready, reset_in_n, bus_select_lo, bus_select_hi, chip_sel_n;
	logic cmd_data_sel, rw_wr_n, en_rd_n, rx_valid, rx_is_data, rd_strobe, init_active, rx_overrun;
	logic [7:0] bus_i, bus_o, bus_oe, rx_byte, rd_data;
	ohb_mode_e host_mode;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	ohb_host_if dut (.clock, .rst, .reset_in_n, .bus_select_lo, .bus_select_hi, .chip_sel_n,
		.cmd_data_sel, .rw_wr_n, .en_rd_n, .host_data_bus_i(bus_i), .host_data_bus_o(bus_o),
		.host_data_bus_oe(bus_oe), .rx_valid, .rx_ready, .rx_byte, .rx_is_data, .rd_data,
		.rd_strobe, .init_active, .host_mode, .rx_overrun);
	ohb_host_model host (.clock, .reset_in_n, .bus_select_lo, .bus_select_hi, .chip_sel_n,
		.cmd_data_sel, .rw_wr_n, .en_rd_n, .host_data_bus_i(bus_i), .host_data_bus_o(bus_o),
		.host_data_bus_oe(bus_oe));
	always #10 clock = ~clock;
	task automatic summarize;
		if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			summarize;
		end
	end
	// ****
	// Scenarios
	// ****
	task automatic get(input logic [7:0] eb, input logic ed);
		int n;
		n = 0;
		@(negedge clock);
		while (rx_valid !== 1'b1 && n < 60) begin
			@(negedge clock);
			n++;
		end
		`CHK("rx_valid", 1'b1, rx_valid)
		`CHK("rx_byte", eb, rx_byte)
		`CHK("rx_is_data", ed, rx_is_data)
		@(posedge clock);
		rx_ready <= 1'b1;
		@(posedge clock);
		rx_ready <= 1'b0;
	endtask : get
	task automatic t_epar;
		logic [7:0] g;
		rd_data <= 8'h3c;
		host.par(1'b0, 1'b0, 1'b0, 8'ha5, g);
		get(8'ha5, 1'b0);
		host.par(1'b0, 1'b1, 1'b0, 8'h00, g);
		`CHK("read data", 8'h3c, g)
		host.par(1'b1, 1'b0, 1'b1, 8'h77, g);
		repeat (10) @(negedge clock);
		`CHK("rx_valid", 1'b0, rx_valid)
	endtask : t_epar
	task automatic t_stall;
		logic [7:0] g;
		for (int i = 0; i < 3; i++) host.par(1'b0, 1'b0, i[0], 8'h10 + 8'(i), g);
		@(negedge clock);
		`CHK("rx_overrun", 1'b1, rx_overrun)
		get(8'h10, 1'b0);
		get(8'h11, 1'b1);
		repeat (4) @(negedge clock);
		`CHK("rx_valid", 1'b0, rx_valid)
	endtask : t_stall
	task automatic t_modes;
		logic [1:0] hl [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
		logic [3:0] em [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
		for (int i = 0; i < 4; i++) begin
			host.set_mode(hl[i]);
			`CHK("host_mode", em[i], host_mode)
			`CHK("rx_overrun", 1'b0, rx_overrun)
			`CHK("init_active", 1'b0, init_active)
		end
	endtask : t_modes
	task automatic t_spar;
		logic [7:0] g;
		rd_data <= 8'h5a;
		host.par(1'b0, 1'b0, 1'b1, 8'h96, g);
		get(8'h96, 1'b1);
		host.par(1'b0, 1'b1, 1'b0, 8'h00, g);
		`CHK("read data", 8'h5a, g)
	endtask : t_spar
	task automatic t_spi;
		host.set_mode(2'h0);
		host.spi(1'b1, 8'hd2);
		get(8'hd2, 1'b1);
		host.spi(1'b0, 8'h2d);
		get(8'h2d, 1'b0);
	endtask : t_spi
	task automatic t_i2c;
		logic [2:0] a;
		host.set_mode(2'h1);
		host.i2c({I2C_ADDR_DEFAULT, 1'b0, 8'h40, 8'hc3}, a);
		`CHK("i2c ack", 3'h7, a)
		get(8'hc3, 1'b1);
		host.i2c({I2C_ADDR_DEFAULT ^ 7'h01, 1'b0, 8'h40, 8'h3c}, a);
		`CHK("i2c ack", 3'h0, a)
		`CHK("rx_valid", 1'b0, rx_valid)
	endtask : t_i2c
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		rx_ready = 1'b0;
		rd_data = 8'h00;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		host.set_mode(2'h2);
		t_epar;
		t_stall;
		t_modes;
		host.set_mode(2'h3);
		t_spar;
		t_spi;
		t_i2c;
		summarize;
	end
endmodule : test_oled_host_bus_interface
`default_nettype wire
